// [logic/brw_tag.sv]
// Tag end: parses read/write requests, answers them, tunnels data to the host
`timescale 1ns/1ps
`include "brw_consts.svh"

module brw_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_r [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	assign in_ready = cnt_r != (AW + 1)'(D);
	assign out_valid = cnt_r != '0;
	assign out_data = mem_r[rp_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk)
	begin
		if (push)
			mem_r[wp_r] <= in_data;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
			if (pop)
				rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
			if (push && !pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop && !push)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule : brw_fifo

module brw_tag (
	input wire logic clk,
	input wire logic rst,
	brw_link.dev lnk,
	input wire logic [63:0] own_id,
	input wire logic [127:0] pwd,
	output logic host_wr_valid,
	input wire logic host_wr_ready,
	output logic [7:0] host_wr_data,
	input wire logic host_rd_valid,
	output logic host_rd_ready,
	input wire logic [7:0] host_rd_data,
	output logic auth_ok
);
	brw_pkg::brw_rx_e rx_st;
	brw_pkg::brw_tx_e tx_st;
	logic [7:0] mem_r [`BRW_MEM_BYTES];
	logic [7:0] blk_r [`BRW_BLK_MAX];
	logic [7:0] cmd_r, k_r, m_r, err_r, b, nb;
	logic [15:0] svc0_r;
	logic [4:0] cnt_r, tcnt_r;
	logic [3:0] idx_r, bi_r;
	logic id_ok_r, len2_r, tun_r, vfy_r, vmatch_r, go_r, auth_r;
	logic rsp_valid_r, rsp_last_r;
	logic [7:0] rsp_data_r;
	logic acc, is_wr, ok, vfy, wr_tun, respond, tx_done, room, ld, have, nl, fifo_ready;

	// ==================================================
	// Helpers
	function automatic logic [9:0] mem_addr(input logic [7:0] blk, input logic [3:0] i);
		mem_addr = {blk[5:0], i};
	endfunction : mem_addr

	function automatic logic [7:0] m_limit(input logic wr, input logic [7:0] k);
		if (!wr)
			m_limit = `BRW_RD_M_MAX;
		else if (k <= `BRW_WR_K_SPLIT)
			m_limit = `BRW_WR_M_MAX_LO;
		else
			m_limit = `BRW_WR_M_MAX_HI;
	endfunction : m_limit

	assign b = lnk.req_data;
	assign is_wr = cmd_r == `BRW_CMD_WRITE;
	assign ok = err_r == `BRW_ST_OK;
	assign vfy = vfy_r && is_wr && m_r == 8'h01;
	assign wr_tun = tun_r && ok && !vfy;
	assign lnk.req_ready = rx_st != brw_pkg::RX_WAIT &&
		!(rx_st == brw_pkg::RX_DATA && wr_tun && !fifo_ready);
	assign acc = lnk.req_valid && lnk.req_ready;
	assign respond = (cmd_r == `BRW_CMD_READ || is_wr) && id_ok_r &&
		rx_st != brw_pkg::RX_CMD && rx_st != brw_pkg::RX_ID;
	assign tx_done = tx_st == brw_pkg::TX_IDLE && !go_r && !rsp_valid_r;
	assign auth_ok = auth_r;

	// ==================================================
	// Request parser
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rx_st <= brw_pkg::RX_CMD;
			cnt_r <= '0;
			idx_r <= '0;
			go_r <= 1'b0;
		end
		else
		begin
			go_r <= 1'b0;
			if (acc)
			begin
				case (rx_st)
					brw_pkg::RX_CMD:
					begin
						cnt_r <= '0;
						rx_st <= brw_pkg::RX_ID;
					end
					brw_pkg::RX_ID:
					begin
						cnt_r <= cnt_r + 1'b1;
						if (cnt_r == `BRW_ID_LAST)
							rx_st <= brw_pkg::RX_K;
					end
					brw_pkg::RX_K:
					begin
						cnt_r <= '0;
						if (b == 8'h00 || b > (is_wr ? `BRW_WR_K_MAX : `BRW_RD_K_MAX))
							rx_st <= brw_pkg::RX_SKIP;
						else
							rx_st <= brw_pkg::RX_SVC;
					end
					brw_pkg::RX_SVC:
					begin
						cnt_r <= cnt_r + 1'b1;
						if (cnt_r == 5'({k_r[3:0], 1'b0} - 5'h01))
							rx_st <= brw_pkg::RX_M;
					end
					brw_pkg::RX_M:
					begin
						cnt_r <= '0;
						idx_r <= '0;
						if (!ok || b == 8'h00 || b > m_limit(is_wr, k_r))
							rx_st <= brw_pkg::RX_SKIP;
						else
							rx_st <= brw_pkg::RX_BL;
					end
					brw_pkg::RX_BL:
					begin
						cnt_r <= cnt_r + 1'b1;
						if ((cnt_r == 5'h01 && len2_r) || cnt_r == 5'h02)
						begin
							cnt_r <= '0;
							idx_r <= idx_r + 1'b1;
							if (idx_r == 4'(m_r - 8'h01))
							begin
								idx_r <= '0;
								rx_st <= is_wr ? brw_pkg::RX_DATA : brw_pkg::RX_SKIP;
							end
						end
					end
					brw_pkg::RX_DATA:
					begin
						cnt_r <= 5'(cnt_r[3:0] + 4'h1);
						if (cnt_r[3:0] == `BRW_BLK_LAST)
						begin
							idx_r <= idx_r + 1'b1;
							if (idx_r == 4'(m_r - 8'h01))
								rx_st <= brw_pkg::RX_SKIP;
						end
					end
					default:
						rx_st <= rx_st;
				endcase
				if (lnk.req_last)
				begin
					rx_st <= respond ? brw_pkg::RX_WAIT : brw_pkg::RX_CMD;
					go_r <= respond;
				end
			end
			else if (rx_st == brw_pkg::RX_WAIT && tx_done)
				rx_st <= brw_pkg::RX_CMD;
		end
	end

	// ==================================================
	// Header fields and status
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cmd_r <= '0;
			k_r <= '0;
			m_r <= '0;
			err_r <= `BRW_ST_OK;
			svc0_r <= '0;
			id_ok_r <= 1'b0;
			len2_r <= 1'b0;
			tun_r <= 1'b0;
			vfy_r <= 1'b0;
		end
		else if (acc)
		begin
			case (rx_st)
				brw_pkg::RX_CMD:
				begin
					cmd_r <= b;
					id_ok_r <= 1'b1;
					err_r <= `BRW_ST_OK;
				end
				brw_pkg::RX_ID:
					if (b != brw_pkg::brw_byte({own_id, 64'h0}, cnt_r[3:0]))
						id_ok_r <= 1'b0;
				brw_pkg::RX_K:
				begin
					k_r <= b;
					if (b == 8'h00 || b > (is_wr ? `BRW_WR_K_MAX : `BRW_RD_K_MAX))
						err_r <= `BRW_ST_SVC;
				end
				brw_pkg::RX_SVC:
					if (cnt_r == 5'h00)
						svc0_r[15:8] <= b;
					else if (cnt_r == 5'h01)
						svc0_r[7:0] <= b;
					else if (b != (cnt_r[0] ? svc0_r[7:0] : svc0_r[15:8]))
						err_r <= `BRW_ST_SVC;
				brw_pkg::RX_M:
				begin
					m_r <= b;
					if (ok && (b == 8'h00 || b > m_limit(is_wr, k_r)))
						err_r <= `BRW_ST_BLKCNT;
				end
				brw_pkg::RX_BL:
					if (cnt_r == 5'h00)
					begin
						len2_r <= b[`BRW_BL_LEN2_BIT];
						vfy_r <= idx_r == 4'h0 && b == 8'h00;
						if (idx_r == 4'h0)
							tun_r <= b[`BRW_BL_MODE_HI:`BRW_BL_MODE_LO] == `BRW_MODE_TUNNEL;
					end
					else if (cnt_r == 5'h01)
						vfy_r <= vfy_r && b == 8'h00;
					else
						vfy_r <= vfy_r && b == `BRW_VFY_B2;
				default:
					cmd_r <= cmd_r;
			endcase
		end
	end

	// ==================================================
	// Block list, block data and password
	always_ff @(posedge clk)
	begin
		if (acc && rx_st == brw_pkg::RX_BL && cnt_r == 5'h01)
			blk_r[idx_r] <= b;
		if (acc && rx_st == brw_pkg::RX_DATA && ok && !tun_r && !vfy)
			mem_r[mem_addr(blk_r[idx_r], cnt_r[3:0])] <= b;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			vmatch_r <= 1'b0;
			auth_r <= 1'b0;
		end
		else if (acc && rx_st == brw_pkg::RX_DATA && ok && vfy)
		begin
			vmatch_r <= (cnt_r == 5'h00 || vmatch_r) &&
				b == brw_pkg::brw_byte(pwd, cnt_r[3:0]);
			if (cnt_r[3:0] == `BRW_BLK_LAST)
				auth_r <= vmatch_r && b == brw_pkg::brw_byte(pwd, cnt_r[3:0]);
		end
	end

	brw_fifo #(.W(`BRW_FIFO_W), .D(`BRW_FIFO_D)) u_wr_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(lnk.req_valid && rx_st == brw_pkg::RX_DATA && wr_tun),
		.in_ready(fifo_ready),
		.in_data(b),
		.out_valid(host_wr_valid),
		.out_ready(host_wr_ready),
		.out_data(host_wr_data)
	);

	// ==================================================
	// Response generator
	assign room = !rsp_valid_r || lnk.rsp_ready;
	assign ld = room && have && tx_st != brw_pkg::TX_IDLE;
	assign host_rd_ready = room && tx_st == brw_pkg::TX_DATA && tun_r;

	always_comb
	begin
		nb = 8'h00;
		nl = 1'b0;
		have = 1'b1;
		case (tx_st)
			brw_pkg::TX_CODE:
				nb = is_wr ? `BRW_RSP_WRITE : `BRW_RSP_READ;
			brw_pkg::TX_ID:
				nb = brw_pkg::brw_byte({own_id, 64'h0}, tcnt_r[3:0]);
			brw_pkg::TX_S1:
				nb = ok ? `BRW_ST_OK : `BRW_ST_ERR;
			brw_pkg::TX_S2:
			begin
				nb = err_r;
				nl = is_wr || !ok;
			end
			brw_pkg::TX_M:
				nb = m_r;
			brw_pkg::TX_DATA:
			begin
				nb = tun_r ? host_rd_data : mem_r[mem_addr(blk_r[bi_r], tcnt_r[3:0])];
				have = !tun_r || host_rd_valid;
				nl = bi_r == 4'(m_r - 8'h01) && tcnt_r[3:0] == `BRW_BLK_LAST;
			end
			default:
				have = 1'b0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tx_st <= brw_pkg::TX_IDLE;
			tcnt_r <= '0;
			bi_r <= '0;
		end
		else if (tx_st == brw_pkg::TX_IDLE)
		begin
			tcnt_r <= '0;
			bi_r <= '0;
			if (go_r)
				tx_st <= brw_pkg::TX_CODE;
		end
		else if (ld)
		begin
			case (tx_st)
				brw_pkg::TX_CODE:
					tx_st <= brw_pkg::TX_ID;
				brw_pkg::TX_ID:
				begin
					tcnt_r <= tcnt_r + 1'b1;
					if (tcnt_r == `BRW_ID_LAST)
						tx_st <= brw_pkg::TX_S1;
				end
				brw_pkg::TX_S1:
					tx_st <= brw_pkg::TX_S2;
				brw_pkg::TX_S2:
					tx_st <= nl ? brw_pkg::TX_IDLE : brw_pkg::TX_M;
				brw_pkg::TX_M:
				begin
					tcnt_r <= '0;
					tx_st <= brw_pkg::TX_DATA;
				end
				brw_pkg::TX_DATA:
				begin
					tcnt_r <= 5'(tcnt_r[3:0] + 4'h1);
					if (tcnt_r[3:0] == `BRW_BLK_LAST)
						bi_r <= bi_r + 1'b1;
					if (nl)
						tx_st <= brw_pkg::TX_IDLE;
				end
				default:
					tx_st <= brw_pkg::TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rsp_valid_r <= 1'b0;
			rsp_last_r <= 1'b0;
			rsp_data_r <= '0;
		end
		else if (ld)
		begin
			rsp_valid_r <= 1'b1;
			rsp_last_r <= nl;
			rsp_data_r <= nb;
		end
		else if (lnk.rsp_ready)
			rsp_valid_r <= 1'b0;
	end

	assign lnk.rsp_valid = rsp_valid_r;
	assign lnk.rsp_data = rsp_data_r;
	assign lnk.rsp_last = rsp_last_r;
endmodule : brw_tag

// [logic/brw_consts.svh]
// Constants for the block read/write command handler
`ifndef BRW_CONSTS_SVH
`define BRW_CONSTS_SVH

// ==================================================
// Command and response codes
`define BRW_CMD_READ 8'h06
`define BRW_CMD_WRITE 8'h08
`define BRW_RSP_READ 8'h07
`define BRW_RSP_WRITE 8'h09

// ==================================================
// Field sizes and limits
`define BRW_ID_LAST 5'h07
`define BRW_BLK_LAST 4'hf
`define BRW_RD_K_MAX 8'h0f
`define BRW_WR_K_MAX 8'h0b
`define BRW_RD_M_MAX 8'h0f
`define BRW_WR_M_MAX_LO 8'h0c
`define BRW_WR_M_MAX_HI 8'h0b
`define BRW_WR_K_SPLIT 8'h08
`define BRW_BLK_MAX 15

// ==================================================
// Status bytes
`define BRW_ST_OK 8'h00
`define BRW_ST_ERR 8'hff
`define BRW_ST_BLKCNT 8'ha2
`define BRW_ST_SVC 8'ha3

// ==================================================
// Block list element layout
`define BRW_BL_LEN2_BIT 7
`define BRW_BL_MODE_HI 6
`define BRW_BL_MODE_LO 4
`define BRW_MODE_TUNNEL 3'h1
`define BRW_VFY_B2 8'h01

// ==================================================
// Storage
`define BRW_MEM_BYTES 1024
`define BRW_FIFO_W 8
`define BRW_FIFO_D 8

`endif

// [logic/brw_pkg.sv]
// State types of each end of the block read/write link and a byte helper shared by both
package brw_pkg;

	typedef enum logic [3:0] {RX_CMD, RX_ID, RX_K, RX_SVC, RX_M, RX_BL, RX_DATA, RX_SKIP,
		RX_WAIT} brw_rx_e;
	typedef enum logic [2:0] {TX_IDLE, TX_CODE, TX_ID, TX_S1, TX_S2, TX_M, TX_DATA} brw_tx_e;
	typedef enum logic [2:0] {Q_IDLE, Q_CMD, Q_ID, Q_K, Q_SVC, Q_M, Q_BL, Q_DATA} brw_q_e;

	// Byte i of a 128-bit value, byte 0 being the most significant
	function automatic logic [7:0] brw_byte(input logic [127:0] v, input logic [3:0] i);
		brw_byte = v[8 * (15 - int'(i)) +: 8];
	endfunction : brw_byte

endpackage : brw_pkg

// [logic/brw_link.sv]
// Byte stream link between the reader end and the tag end
`timescale 1ns/1ps
interface brw_link;
	logic req_valid;
	logic req_ready;
	logic [7:0] req_data;
	logic req_last;
	logic rsp_valid;
	logic rsp_ready;
	logic [7:0] rsp_data;
	logic rsp_last;

	modport dev (input req_valid, input req_data, input req_last, output req_ready,
		output rsp_valid, output rsp_data, output rsp_last, input rsp_ready);
	modport rdr (output req_valid, output req_data, output req_last, input req_ready,
		input rsp_valid, input rsp_data, input rsp_last, output rsp_ready);
endinterface : brw_link

// [logic/brw_reader.sv]
// Reader end: builds read/write/verify requests and collects the answers
`timescale 1ns/1ps
`include "brw_consts.svh"

module brw_reader (
	input wire logic clk,
	input wire logic rst,
	brw_link.rdr lnk,
	input wire logic go,
	input wire logic sel_write,
	input wire logic sel_verify,
	input wire logic sel_tunnel,
	input wire logic [63:0] tag_id,
	input wire logic [3:0] svc_cnt,
	input wire logic [15:0] svc_code,
	input wire logic [3:0] blk_cnt,
	input wire logic [7:0] blk_first,
	input wire logic wd_valid,
	output logic wd_ready,
	input wire logic [7:0] wd_data,
	output logic busy,
	output logic out_valid,
	input wire logic out_ready,
	output logic [7:0] out_data,
	output logic out_last,
	output logic done,
	output logic [7:0] stat1,
	output logic [7:0] stat2
);
	brw_pkg::brw_q_e q_st;
	logic wr_r, vf_r, tn_r;
	logic [63:0] id_r;
	logic [3:0] k_r, m_r, idx_r, rcnt_r;
	logic [15:0] svc_r;
	logic [7:0] first_r, nb, req_data_r;
	logic [4:0] cnt_r;
	logic req_valid_r, req_last_r, ld, have, nl, el_end;

	// ==================================================
	// Request builder
	assign ld = (!req_valid_r || lnk.req_ready) && have;
	assign wd_ready = (!req_valid_r || lnk.req_ready) && q_st == brw_pkg::Q_DATA;
	assign el_end = cnt_r == (vf_r ? 5'h02 : 5'h01);
	assign busy = q_st != brw_pkg::Q_IDLE;

	always_comb
	begin
		nb = 8'h00;
		nl = 1'b0;
		have = 1'b1;
		case (q_st)
			brw_pkg::Q_CMD:
				nb = wr_r ? `BRW_CMD_WRITE : `BRW_CMD_READ;
			brw_pkg::Q_ID:
				nb = brw_pkg::brw_byte({id_r, 64'h0}, cnt_r[3:0]);
			brw_pkg::Q_K:
				nb = {4'h0, k_r};
			brw_pkg::Q_SVC:
				nb = cnt_r[0] ? svc_r[7:0] : svc_r[15:8];
			brw_pkg::Q_M:
			begin
				nb = {4'h0, m_r};
				nl = m_r == 4'h0;
			end
			brw_pkg::Q_BL:
			begin
				if (vf_r)
					nb = (cnt_r == 5'h02) ? `BRW_VFY_B2 : 8'h00;
				else if (cnt_r == 5'h00)
					nb = {1'b1, sel_mode(tn_r), 4'h0};
				else
					nb = first_r + {4'h0, idx_r};
				nl = !wr_r && el_end && idx_r == m_r - 4'h1;
			end
			brw_pkg::Q_DATA:
			begin
				nb = wd_data;
				have = wd_valid;
				nl = idx_r == m_r - 4'h1 && cnt_r[3:0] == `BRW_BLK_LAST;
			end
			default:
				have = 1'b0;
		endcase
	end

	function automatic logic [2:0] sel_mode(input logic tun);
		sel_mode = tun ? `BRW_MODE_TUNNEL : 3'h0;
	endfunction : sel_mode

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			q_st <= brw_pkg::Q_IDLE;
			cnt_r <= '0;
			idx_r <= '0;
			wr_r <= 1'b0;
			vf_r <= 1'b0;
			tn_r <= 1'b0;
			id_r <= '0;
			k_r <= '0;
			m_r <= '0;
			svc_r <= '0;
			first_r <= '0;
		end
		else if (q_st == brw_pkg::Q_IDLE)
		begin
			cnt_r <= '0;
			idx_r <= '0;
			if (go)
			begin
				q_st <= brw_pkg::Q_CMD;
				wr_r <= sel_write || sel_verify;
				vf_r <= sel_verify;
				tn_r <= sel_tunnel;
				id_r <= tag_id;
				k_r <= svc_cnt;
				m_r <= sel_verify ? 4'h1 : blk_cnt;
				svc_r <= svc_code;
				first_r <= blk_first;
			end
		end
		else if (ld)
		begin
			cnt_r <= cnt_r + 1'b1;
			case (q_st)
				brw_pkg::Q_CMD:
				begin
					cnt_r <= '0;
					q_st <= brw_pkg::Q_ID;
				end
				brw_pkg::Q_ID:
					if (cnt_r == `BRW_ID_LAST)
						q_st <= brw_pkg::Q_K;
				brw_pkg::Q_K:
				begin
					cnt_r <= '0;
					q_st <= (k_r == 4'h0) ? brw_pkg::Q_M : brw_pkg::Q_SVC;
				end
				brw_pkg::Q_SVC:
					if (cnt_r == 5'({k_r, 1'b0} - 5'h01))
						q_st <= brw_pkg::Q_M;
				brw_pkg::Q_M:
				begin
					cnt_r <= '0;
					q_st <= brw_pkg::Q_BL;
				end
				brw_pkg::Q_BL:
					if (el_end)
					begin
						cnt_r <= '0;
						idx_r <= idx_r + 1'b1;
						if (idx_r == m_r - 4'h1)
						begin
							idx_r <= '0;
							q_st <= brw_pkg::Q_DATA;
						end
					end
				brw_pkg::Q_DATA:
				begin
					cnt_r <= 5'(cnt_r[3:0] + 4'h1);
					if (cnt_r[3:0] == `BRW_BLK_LAST)
						idx_r <= idx_r + 1'b1;
				end
				default:
					q_st <= brw_pkg::Q_IDLE;
			endcase
			if (nl)
				q_st <= brw_pkg::Q_IDLE;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			req_valid_r <= 1'b0;
			req_last_r <= 1'b0;
			req_data_r <= '0;
		end
		else if (ld)
		begin
			req_valid_r <= 1'b1;
			req_last_r <= nl;
			req_data_r <= nb;
		end
		else if (lnk.req_ready)
			req_valid_r <= 1'b0;
	end

	assign lnk.req_valid = req_valid_r;
	assign lnk.req_data = req_data_r;
	assign lnk.req_last = req_last_r;

	// ==================================================
	// Answer collector
	assign lnk.rsp_ready = !out_valid || out_ready;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			out_valid <= 1'b0;
			out_data <= '0;
			out_last <= 1'b0;
			done <= 1'b0;
			rcnt_r <= '0;
			stat1 <= '0;
			stat2 <= '0;
		end
		else
		begin
			done <= 1'b0;
			if (lnk.rsp_valid && lnk.rsp_ready)
			begin
				out_valid <= 1'b1;
				out_data <= lnk.rsp_data;
				out_last <= lnk.rsp_last;
				rcnt_r <= (rcnt_r == 4'hf) ? rcnt_r : rcnt_r + 1'b1;
				if (rcnt_r == 4'h9)
					stat1 <= lnk.rsp_data;
				if (rcnt_r == 4'ha)
					stat2 <= lnk.rsp_data;
				if (lnk.rsp_last)
				begin
					rcnt_r <= '0;
					done <= 1'b1;
				end
			end
			else if (out_ready)
				out_valid <= 1'b0;
		end
	end
endmodule : brw_reader

// [tb/brw_link_properties.sv]
// Protocol checker for the request/answer link between reader and tag
`timescale 1ns/1ps

module brw_link_properties (
	input wire logic clk,
	input wire logic rst,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [7:0] req_data,
	input wire logic req_last,
	input wire logic rsp_valid,
	input wire logic rsp_ready,
	input wire logic [7:0] rsp_data,
	input wire logic rsp_last
);
	// ==================================================
	// Frame position tracking
	logic [8:0] ri_r;
	logic [8:0] ai_r;
	logic [7:0] cmd_r;
	logic [7:0] s1_r;
	logic [63:0] id_r;
	wire req_tk = req_valid && req_ready;
	wire rsp_tk = rsp_valid && rsp_ready;

	always_ff @(posedge clk)
		if (rst) ri_r <= '0;
		else if (req_tk) ri_r <= req_last ? 9'h000 : ri_r + 9'h001;
	always_ff @(posedge clk)
		if (rst) ai_r <= '0;
		else if (rsp_tk) ai_r <= rsp_last ? 9'h000 : ai_r + 9'h001;
	always_ff @(posedge clk)
		if (req_tk && ri_r == 9'h000) cmd_r <= req_data;
	always_ff @(posedge clk)
		if (req_tk && ri_r >= 9'h001 && ri_r <= 9'h008) id_r <= {id_r[55:0], req_data};
	always_ff @(posedge clk)
		if (rsp_tk && ai_r == 9'h009) s1_r <= rsp_data;

	// ==================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_frame_end;
		req_valid && req_ready && req_last;
	endsequence
	sequence s_status2;
		rsp_valid && ai_r == 9'h00a;
	endsequence

	AST_RSP_HOLD: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data)
		&& $stable(rsp_last)) else $error("answer byte changed before taken");
	AST_REQ_HOLD: assert property (req_valid && !req_ready |=> req_valid && $stable(req_data)
		&& $stable(req_last)) else $error("request byte changed before taken");
	AST_CODE: assert property (rsp_valid && ai_r == 9'h000
		|-> rsp_data == 8'(cmd_r + 8'h01))
		else $error("answer code does not follow command code");
	AST_ID_ECHO: assert property (rsp_valid && ai_r >= 9'h001 && ai_r <= 9'h008
		|-> rsp_data == 8'(id_r >> (64 - 8 * ai_r))) else $error("identifier not echoed");
	AST_ERR_CUT: assert property (s_status2 and s1_r == 8'hff |-> rsp_last)
		else $error("error answer carries more than status");
	AST_ERR_CODE: assert property (s_status2 and s1_r == 8'hff
		|-> rsp_data == 8'ha2 || rsp_data == 8'ha3) else $error("bad error status code");
	AST_WR_END: assert property (s_status2 and cmd_r == 8'h08 |-> rsp_last)
		else $error("write answer longer than status");
	AST_RD_CONT: assert property (s_status2 and cmd_r == 8'h06 and s1_r == 8'h00
		|-> !rsp_last) else $error("good read answer ends at status");
	AST_LATENCY: assert property ($rose(rsp_valid) && ai_r == 9'h000
		|-> $past(req_tk && req_last, 3))
		else $error("answer start not three cycles after frame end");
	AST_QUIET: assert property (s_frame_end |=> !rsp_valid [*2])
		else $error("answer started too early");
	AST_NO_OVERLAP: assert property (rsp_valid |-> !req_ready)
		else $error("request taken while answering");
endmodule : brw_link_properties

// [tb/block_read_write_command_handler_tb.sv]
// Self-checking bench joining reader and tag ends
`timescale 1ns/1ps

module block_read_write_command_handler_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic go = 1'b0, sel_write = 1'b0, sel_verify = 1'b0, sel_tunnel = 1'b0;
	logic [63:0] own_id = 64'h1122334455667788;
	logic [63:0] tag_id = 64'h0;
	logic [127:0] pwd = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
	logic [3:0] svc_cnt = 4'h1, blk_cnt = 4'h1;
	logic [15:0] svc_code = 16'h0900;
	logic [7:0] blk_first = 8'h00, wd_data = 8'h00, host_rd_data = 8'h00;
	logic wd_valid = 1'b0, out_ready = 1'b0, host_wr_ready = 1'b0, host_rd_valid = 1'b1;
	logic wd_ready, busy, out_valid, out_last, done, host_wr_valid, host_rd_ready, auth_ok;
	logic [7:0] out_data, stat1, stat2, host_wr_data;
	logic [7:0] wq[$], got[$], hw[$], wdat[$], exq[$];
	logic [7:0] mem [0:63][0:15];
	int error_cnt = 0;
	int n_tests = 0;
	int lpos = 0;

	always #25 clk = ~clk;

	brw_link lnk ();
	brw_tag brw_tag_inst (.clk(clk), .rst(rst), .lnk(lnk), .own_id(own_id), .pwd(pwd),
		.host_wr_valid(host_wr_valid), .host_wr_ready(host_wr_ready),
		.host_wr_data(host_wr_data), .host_rd_valid(host_rd_valid),
		.host_rd_ready(host_rd_ready), .host_rd_data(host_rd_data), .auth_ok(auth_ok));
	brw_reader brw_reader_inst (.clk(clk), .rst(rst), .lnk(lnk), .go(go),
		.sel_write(sel_write), .sel_verify(sel_verify), .sel_tunnel(sel_tunnel),
		.tag_id(tag_id), .svc_cnt(svc_cnt), .svc_code(svc_code), .blk_cnt(blk_cnt),
		.blk_first(blk_first), .wd_valid(wd_valid), .wd_ready(wd_ready), .wd_data(wd_data),
		.busy(busy), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
		.out_last(out_last), .done(done), .stat1(stat1), .stat2(stat2));
	brw_link_properties brw_link_properties_inst (.clk(clk), .rst(rst),
		.req_valid(lnk.req_valid), .req_ready(lnk.req_ready), .req_data(lnk.req_data),
		.req_last(lnk.req_last), .rsp_valid(lnk.rsp_valid), .rsp_ready(lnk.rsp_ready),
		.rsp_data(lnk.rsp_data), .rsp_last(lnk.rsp_last));

	// ==================================================
	// Streams around the two ends, with random stalls on the sinks
	always @(posedge clk)
	begin
		if (wd_valid && wd_ready) void'(wq.pop_front());
		wd_valid <= wq.size() != 0;
		wd_data <= wq.size() != 0 ? wq[0] : 8'h00;
		if (out_valid && out_ready) got.push_back(out_data);
		if (out_valid && out_ready && out_last) lpos = got.size();
		out_ready <= $urandom_range(3) != 0;
		if (host_wr_valid && host_wr_ready) hw.push_back(host_wr_data);
		host_wr_ready <= $urandom_range(1) != 0;
		if (host_rd_valid && host_rd_ready) host_rd_data <= host_rd_data + 8'h01;
		if (!host_rd_valid || host_rd_ready) host_rd_valid <= $urandom_range(1) != 0;
	end

	// ==================================================
	// Checking helpers
	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", name, e, s);
			error_cnt++;
		end
	endtask : chk

	function automatic void expect_answer(input logic w, input logic [63:0] id,
		input logic [7:0] s2, input logic [3:0] m, input logic t, input logic [7:0] h0,
		input logic [7:0] b);
		exq = {w ? 8'h09 : 8'h07};
		for (int i = 7; i >= 0; i--) exq.push_back(id[8 * i +: 8]);
		exq.push_back(s2 == 8'h00 ? 8'h00 : 8'hff);
		exq.push_back(s2);
		if (!w && s2 == 8'h00)
		begin
			exq.push_back({4'h0, m});
			for (int i = 0; i < 16 * m; i++)
				exq.push_back(t ? 8'(h0 + i) : mem[(b + i / 16) % 64][i % 16]);
		end
	endfunction : expect_answer

	// One complete request and answer; b is the flip mask for a verify
	task automatic run(input logic w, input logic v, input logic t, input logic [63:0] id,
		input logic [3:0] k, input logic [3:0] m, input logic [7:0] b, input logic [7:0] s2);
		logic [7:0] h0;
		int n;
		int mm;
		mm = v ? 1 : m;
		got = {};
		lpos = 0;
		hw = {};
		wdat = {};
		h0 = host_rd_data;
		if (w)
			for (int i = 0; i < 16 * mm; i++)
				wdat.push_back(v ? pwd[8 * (15 - i) +: 8] ^ b : 8'($urandom));
		wq = wdat;
		@(posedge clk);
		{sel_write, sel_verify, sel_tunnel} <= {w, v, t};
		{tag_id, svc_cnt, blk_cnt, blk_first} <= {id, k, m, v ? 8'h01 : b};
		svc_code <= 16'($urandom);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		for (n = 0; n < (id === own_id ? 3000 : 300) && done !== 1'b1; n++) @(negedge clk);
		if (id === own_id) chk("answer done", 1, done);
		for (n = 0; n < 64 && (out_valid !== 1'b0 || host_wr_valid !== 1'b0); n++) @(negedge clk);
		expect_answer(w, id, s2, m, t, h0, b);
		if (id !== own_id) exq = {};
		chk("answer length", exq.size(), got.size());
		chk("last flag position", exq.size(), lpos);
		for (int i = 0; i < exq.size(); i++) chk("answer byte", exq[i], got[i]);
		chk("reader idle", 0, busy);
		if (id === own_id) chk("status one", s2 == 8'h00 ? 8'h00 : 8'hff, stat1);
		if (id === own_id) chk("status two", s2, stat2);
		if (v) chk("auth", b == 8'h00, auth_ok);
		if (w && t) chk("host write count", wdat.size(), hw.size());
		if (w && t) foreach (wdat[i]) chk("host write byte", wdat[i], hw[i]);
		if (w && !t && !v && s2 == 8'h00)
			foreach (wdat[i]) mem[(b + i / 16) % 64][i % 16] = wdat[i];
		$display("Test done: write %0d verify %0d tunnel %0d k %0d m %0d", w, v, t, k, m);
	endtask : run

	task automatic conclude;
		$display("Checks %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	// ==================================================
	// Main sequence and watchdog
	initial
	begin
		#(50 * 40000);
		error_cnt++;
		conclude();
	end

	initial
	begin
		void'($urandom(32'h3a20));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		run(1, 0, 0, own_id, 4'h1, 4'h3, 8'h05, 8'h00);
		run(0, 0, 0, own_id, 4'($urandom_range(15, 1)), 4'h3, 8'h05, 8'h00);
		run(0, 0, 0, own_id, 4'hf, 4'h1, 8'h07, 8'h00);
		run(1, 0, 0, own_id, 4'h8, 4'hc, 8'h14, 8'h00);
		run(0, 0, 0, own_id, 4'h1, 4'hc, 8'h14, 8'h00);
		run(1, 0, 0, own_id, 4'hb, 4'hb, 8'h30, 8'h00);
		run(1, 0, 0, own_id, 4'h9, 4'hc, 8'h05, 8'ha2);
		run(1, 0, 0, own_id, 4'hc, 4'h1, 8'h05, 8'ha3);
		run(1, 0, 0, own_id, 4'h0, 4'h1, 8'h05, 8'ha3);
		run(0, 0, 0, own_id, 4'h0, 4'h1, 8'h05, 8'ha3);
		run(0, 0, 0, own_id, 4'h1, 4'h0, 8'h05, 8'ha2);
		run(1, 0, 0, own_id, 4'h2, 4'h0, 8'h05, 8'ha2);
		run(0, 0, 0, own_id, 4'h1, 4'h3, 8'h05, 8'h00);
		run(1, 0, 1, own_id, 4'h1, 4'h2, 8'h00, 8'h00);
		run(0, 0, 1, own_id, 4'h1, 4'h2, 8'h00, 8'h00);
		run(1, 1, 0, own_id, 4'h1, 4'h1, 8'h00, 8'h00);
		run(1, 1, 0, own_id, 4'h1, 4'h1, 8'h40, 8'h00);
		run(0, 0, 0, own_id ^ 64'h1, 4'h1, 4'h1, 8'h05, 8'h00);
		conclude();
	end
endmodule : block_read_write_command_handler_tb
